//--- verilog/tdh_host_port.sv
// Purpose: Host-side parallel port logic of a cartridge tape drive
// Assumes: All host lines asynchronous, active low; drive front end is raw
// Notes:   Tape position and read bit stream come from the mechanics side
`timescale 1ns/100ps
module tdh_host_port
   import tdh_pkg::*;
#(
   parameter int FIRST_CYCLES = tdh_pkg::FIRST_CYC,
   parameter int NEXT_CYCLES  = tdh_pkg::NEXT_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        host_reset_b,
   input  wire logic        run_b,
   input  wire logic        halt_b,
   input  wire logic        direction_level,
   input  wire logic        write_mode_level,
   input  wire logic        unit_pick_lo,
   input  wire logic        unit_pick_hi,
   input  wire logic        rx_bus_drive_b,
   input  wire logic        tx_holding_strobe_b,
   input  wire logic [7:0]  data_in,
   output logic [7:0]       data_out,
   output logic             data_oe,
   output logic             tape_start_mark_b,
   output logic             ready_b,
   output logic             gap_detected_b,
   output logic             tx_holding_vacant_b,
   output logic             rx_byte_waiting_b,
   output logic             short_byte_error_b,
   output logic [3:0]       unit_select,
   output logic             motor_fwd,
   output logic             motor_rev,
   output logic             head_current,
   output logic [7:0]       tx_byte,
   output logic             tx_byte_valid,
   input  wire logic        tx_byte_taken,
   input  wire logic        at_start,
   input  wire logic        past_load_mark,
   input  wire logic        past_end_warning,
   input  wire logic        write_permit,
   input  wire logic        gap_seen,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit,
   input  wire logic        rx_frame_end
);
   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   localparam int NS = 8;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] lvl;
   logic [NS-1:0] fall;
   logic [NS-1:0] rise;

   assign raw_in = {host_reset_b, run_b, halt_b, direction_level, write_mode_level,
                    rx_bus_drive_b, tx_holding_strobe_b, 1'b1};

   tdh_sync #(.W(NS)) u_sync (
      .clk  (clk),
      .rst_b(rst_b),
      .din  (raw_in),
      .dout (lvl),
      .fall (fall),
      .rise (rise)
   );

   wire hreset_n   = lvl[7];
   wire run_rise   = rise[6];
   wire run_low    = ~lvl[6];
   wire halt_low   = ~lvl[5];
   wire dir_fwd    = lvl[4];
   wire write_mode = ~lvl[3];
   wire rbe_low    = ~lvl[2];
   wire rbe_fall   = fall[2];
   wire strobe_rise= rise[1];
   wire strobe_fall= fall[1];

   // Host reset acts like the internal reset on all control state except the tx_byte, data_out and data_oe registers
   wire clr = !rst_b || !hreset_n;

   // ------------------------------------------------------------
   // Unit selection
   // ------------------------------------------------------------
   function automatic logic [3:0] pick_decode(input logic lo, input logic hi);
      pick_decode = 4'h1 << {~hi, ~lo};
   endfunction

   assign unit_select = pick_decode(unit_pick_lo, unit_pick_hi);

   // ------------------------------------------------------------
   // Tape motion
   // ------------------------------------------------------------
   tdh_motion_t motion;
   tdh_motion_t next_motion;
   logic        run_seen_halt;

   // Halt seen anywhere in the run pulse cancels the start
   always_ff @(posedge clk) begin
      if (clr || run_rise)
         run_seen_halt <= 1'b0;
      else if (run_low && halt_low)
         run_seen_halt <= 1'b1;
   end

   wire start_ok = run_rise && !halt_low && !run_seen_halt;
   wire rev_ok   = !at_start;

   always_comb begin
      next_motion = motion;
      case (motion)
         TDH_IDLE: begin
            if (start_ok && dir_fwd)
               next_motion = TDH_FWD;
            else if (start_ok && !dir_fwd && rev_ok)
               next_motion = TDH_REV;
         end
         TDH_FWD: begin
            if (halt_low)
               next_motion = TDH_IDLE;
            else if (start_ok && !dir_fwd && rev_ok)
               next_motion = TDH_REV;
         end
         TDH_REV: begin
            if (halt_low || at_start)
               next_motion = TDH_IDLE;
            else if (start_ok && dir_fwd)
               next_motion = TDH_FWD;
         end
         default: next_motion = TDH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (clr)
         motion <= TDH_IDLE;
      else
         motion <= next_motion;
   end

   assign motor_fwd    = (motion == TDH_FWD);
   assign motor_rev    = (motion == TDH_REV);
   assign head_current = write_mode && (motion != TDH_IDLE);

   // ------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------
   logic force_ready;

   // Ready stays forced after reset until the tape next moves; misuse can harm the tape
   always_ff @(posedge clk) begin
      if (clr)
         force_ready <= 1'b1;
      else if (motion != TDH_IDLE)
         force_ready <= 1'b0;
   end

   wire in_zone  = past_load_mark && !past_end_warning;
   wire ready_ok = write_mode ? (in_zone && write_permit) : in_zone;

   assign ready_b           = !(ready_ok || force_ready);
   assign tape_start_mark_b = !at_start;
   assign gap_detected_b    = !(gap_seen && motion != TDH_IDLE);

   // ------------------------------------------------------------
   // Write buffer
   // ------------------------------------------------------------
   logic        vacant;
   logic        first_done;
   logic [19:0] pace;

   // Byte is latched at the strobe's leading edge, while the host holds the bus
   always_ff @(posedge clk) begin
      if (!rst_b)
         tx_byte <= BUS_RST;
      else if (strobe_fall)
         tx_byte <= data_in;
   end

   always_ff @(posedge clk) begin
      if (clr)
         tx_byte_valid <= 1'b0;
      else if (strobe_rise)
         tx_byte_valid <= 1'b1;
      else if (tx_byte_taken)
         tx_byte_valid <= 1'b0;
   end

   // Pacing counter spaces vacant assertions; first byte of a block is fast
   always_ff @(posedge clk) begin
      if (clr || motion == TDH_IDLE) begin
         vacant     <= 1'b1;
         first_done <= 1'b0;
         pace       <= '0;
      end else if (strobe_fall) begin
         vacant     <= 1'b0;
         first_done <= 1'b1;
         pace       <= first_done ? 20'(NEXT_CYCLES) : 20'(FIRST_CYCLES);
      end else if (pace != '0) begin
         pace <= pace - 20'd1;
      end else if (!tx_byte_valid) begin
         vacant <= 1'b1;
      end
   end

   assign tx_holding_vacant_b = !vacant;

   // ------------------------------------------------------------
   // Read buffer
   // ------------------------------------------------------------
   logic [7:0] shifter;
   logic [3:0] bit_cnt;
   logic [7:0] rx_hold;
   logic       waiting;
   logic       short_err;
   logic       armed;

   always_ff @(posedge clk) begin
      if (clr) begin
         shifter   <= BUS_RST;
         bit_cnt   <= '0;
         rx_hold   <= BUS_RST;
         waiting   <= 1'b0;
         short_err <= 1'b0;
         armed     <= 1'b0;
      end else begin
         if (rbe_fall) begin
            waiting   <= 1'b0;
            short_err <= 1'b0;
         end
         if (rx_bit_valid) begin
            shifter <= {shifter[6:0], rx_bit};
            bit_cnt <= (bit_cnt == CNT_FULL) ? 4'h1 : bit_cnt + 4'h1;
         end
         if (rx_bit_valid && bit_cnt == CNT_FULL - 4'h1) begin
            rx_hold <= {shifter[6:0], rx_bit};
            bit_cnt <= '0;
            armed   <= 1'b1;
            if (armed) begin
               waiting   <= 1'b1;
               short_err <= 1'b0;
            end
         end else if (rx_frame_end && bit_cnt != '0) begin
            rx_hold <= shifter;
            bit_cnt <= '0;
            if (armed) begin
               waiting   <= 1'b1;
               short_err <= 1'b1;
            end
         end
      end
   end

   // First full byte after reset arms the flags but raises neither flag itself
   assign rx_byte_waiting_b  = !waiting;
   assign short_byte_error_b = !short_err;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         data_out <= BUS_RST;
         data_oe  <= 1'b0;
      end else begin
         data_out <= rx_hold;
         data_oe  <= rbe_low && !write_mode;
      end
   end
endmodule

//--- verilog/tdh_pkg.sv
// Purpose: Constants for the tape drive host port
// Assumes: 25 MHz clock, all host lines active low
// Notes:   Contract list below
// Contract
// - Low level means asserted on every line
// - Start mark output; refuse reverse there
// - Read mode ready between load and warning
// - Write ready also needs write permit
// - Direction level picks forward or reverse
// - Run pulse; motion starts on rising edge
// - Halt pulse stops tape motion
// - Halt beats run when both low
// - Reset clears logic, forces ready, halts
// - Two pick lines decode one of four units
// - Eight-bit shared bus, bit zero least
// - Write mode low enables head current
// - Bus drive shows byte, clears both flags
// - Gap output pulses on each detected gap
// - Vacant flag timing after first byte
// - Strobe latches byte, clears vacant flag
// - Waiting flag holds until drive clears
// - Flags quiet until one full byte read
// - Short byte flag with fewer than eight bits
package tdh_pkg;
   localparam int CLK_MHZ          = 25;
   localparam int FIRST_MIN_NS     = 16700;
   localparam int FIRST_CYC        = (FIRST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int NEXT_MIN_NS      = 350000;
   localparam int NEXT_CYC         = (NEXT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int BYTE_BITS        = 8;
   localparam int SYNC_STAGES      = 2;
   localparam logic [7:0] BUS_RST  = 8'h00;
   localparam logic [3:0] CNT_FULL = 4'h8;

   typedef enum logic [1:0] {
      TDH_IDLE = 2'b00,
      TDH_FWD  = 2'b01,
      TDH_REV  = 2'b10
   } tdh_motion_t;
endpackage

//--- verilog/tdh_sync.sv
// Purpose: Two-flop synchroniser with edge outputs for a bank of lines
// Assumes: Single clock, lines asynchronous to it
// Notes:   Idle level of every line is high
`timescale 1ns/100ps
module tdh_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout,
   output logic [W-1:0]      fall,
   output logic [W-1:0]      rise
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] prev;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage1 <= '1;
         stage2 <= '1;
         prev   <= '1;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         prev   <= stage2;
      end
   end

   assign dout = stage2;
   assign fall = prev & ~stage2;
   assign rise = ~prev & stage2;
endmodule

//--- verification/tdh_host_port_asserts.sv
// Purpose: Port assertions for the tape drive host port
// Assumes: Host lines held for at least five clocks
// Notes:   Sync latency is three clocks, so windows allow for it
`timescale 1ns/100ps
module tdh_chk (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       host_reset_b,
   input wire logic       halt_b,
   input wire logic       direction_level,
   input wire logic       write_mode_level,
   input wire logic       unit_pick_lo,
   input wire logic       unit_pick_hi,
   input wire logic       rx_bus_drive_b,
   input wire logic       tx_holding_strobe_b,
   input wire logic       data_oe,
   input wire logic       tape_start_mark_b,
   input wire logic       ready_b,
   input wire logic       gap_detected_b,
   input wire logic       tx_holding_vacant_b,
   input wire logic       rx_byte_waiting_b,
   input wire logic       short_byte_error_b,
   input wire logic [3:0] unit_select,
   input wire logic       motor_fwd,
   input wire logic       motor_rev,
   input wire logic       at_start,
   input wire logic       gap_seen
);
   // ----
   // Assertions
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic mov = motor_fwd | motor_rev;
   a_unit_decode: assert property (unit_select == {~unit_pick_lo & ~unit_pick_hi,
      unit_pick_lo & ~unit_pick_hi, ~unit_pick_lo & unit_pick_hi, unit_pick_lo & unit_pick_hi})
      else $error("unit decode");
   a_start_mark: assert property (tape_start_mark_b == !at_start)
      else $error("start mark");
   a_no_rev_start: assert property (at_start [*2] |-> !motor_rev)
      else $error("reverse at start");
   a_gap_out: assert property (gap_detected_b == !(gap_seen && mov))
      else $error("gap output");
   a_strobe_clear: assert property ($fell(tx_holding_strobe_b) |-> ##[1:4] tx_holding_vacant_b)
      else $error("vacant not cleared");
   a_drive_clear: assert property ($fell(rx_bus_drive_b) |->
      ##[1:4] (rx_byte_waiting_b && short_byte_error_b)) else $error("flags not cleared");
   a_oe_on: assert property ((!rx_bus_drive_b && write_mode_level) [*5] |-> data_oe)
      else $error("bus not driven");
   a_halt_wins: assert property ((!halt_b) [*5] |-> !mov)
      else $error("halt ignored");
   a_reset_hold: assert property ((!host_reset_b) [*5] |-> !mov && !ready_b)
      else $error("host reset");
   a_dir_pick: assert property ($rose(mov) |-> motor_fwd == direction_level)
      else $error("direction");
   c_fwd: cover property ($rose(motor_fwd));
   c_wait: cover property ($fell(rx_byte_waiting_b));
   c_short: cover property ($fell(short_byte_error_b));
endmodule
bind tdh_host_port tdh_chk chk_u (.clk, .rst_b, .host_reset_b, .halt_b, .direction_level,
   .write_mode_level, .unit_pick_lo, .unit_pick_hi, .rx_bus_drive_b, .tx_holding_strobe_b,
   .data_oe, .tape_start_mark_b, .ready_b, .gap_detected_b, .tx_holding_vacant_b,
   .rx_byte_waiting_b, .short_byte_error_b, .unit_select, .motor_fwd, .motor_rev, .at_start,
   .gap_seen);

//--- verification/tdh_mech_model.sv
// Purpose: Far-side consumer of write buffer bytes
// Assumes: Takes a byte four clocks after it is offered
// Notes:   Slow on purpose, so the vacant flag is held off a while
`timescale 1ns/100ps
module tdh_mech_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic tx_byte_valid,
   output logic      tx_byte_taken
);
   logic [1:0] wait_cnt;
   always_ff @(posedge clk) begin
      if (!rst_b || !tx_byte_valid || tx_byte_taken) begin
         wait_cnt      <= 2'h0;
         tx_byte_taken <= 1'b0;
      end else begin
         wait_cnt      <= wait_cnt + 2'h1;
         tx_byte_taken <= (wait_cnt == 2'h3);
      end
   end
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the tape drive host port
// Assumes: Short vacant counts of 16 and 20 clocks
// Notes:   Run, strobe and reset pulses are 13 clocks, halt and bus drive 6, above every minimum width
`timescale 1ns/100ps
module tb;
   logic       clk = 1'b0, rst_b = 1'b0, host_reset_b = 1'b1, run_b = 1'b1, halt_b = 1'b1;
   logic       direction_level = 1'b1, write_mode_level = 1'b1;
   logic       unit_pick_lo = 1'b1, unit_pick_hi = 1'b1;
   logic       rx_bus_drive_b = 1'b1, tx_holding_strobe_b = 1'b1;
   logic [7:0] data_in = 8'h00, data_out, tx_byte;
   logic       at_start = 1'b0, past_load_mark = 1'b0, past_end_warning = 1'b0;
   logic       write_permit = 1'b1, gap_seen = 1'b0;
   logic       rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_frame_end = 1'b0;
   logic [3:0] unit_select;
   logic       data_oe, tape_start_mark_b, ready_b, gap_detected_b, tx_holding_vacant_b;
   logic       rx_byte_waiting_b, short_byte_error_b, motor_fwd, motor_rev, head_current;
   logic       tx_byte_valid, tx_byte_taken;
   int         bad_count = 0, num_checks = 0, cyc = 0;
   // First count must outlast the 13-clock strobe, or vacant returns while it is still low
   tdh_host_port #(.FIRST_CYCLES(16), .NEXT_CYCLES(20)) dut_u (.clk, .rst_b, .host_reset_b,
      .run_b, .halt_b, .direction_level, .write_mode_level, .unit_pick_lo, .unit_pick_hi,
      .rx_bus_drive_b, .tx_holding_strobe_b, .data_in, .data_out, .data_oe,
      .tape_start_mark_b, .ready_b, .gap_detected_b, .tx_holding_vacant_b,
      .rx_byte_waiting_b, .short_byte_error_b, .unit_select, .motor_fwd, .motor_rev,
      .head_current, .tx_byte, .tx_byte_valid, .tx_byte_taken, .at_start, .past_load_mark,
      .past_end_warning, .write_permit, .gap_seen, .rx_bit_valid, .rx_bit, .rx_frame_end);
   tdh_mech_model mech_u (.clk, .rst_b, .tx_byte_valid, .tx_byte_taken);
   // ----
   // Clock, timeout and shared tasks
   // ----
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         results();
      end
   end
   task automatic results;
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic run(input logic dir, input logic hlt);
      direction_level <= dir;
      tick(1);
      run_b <= 1'b0;
      halt_b <= ~hlt;
      tick(13);
      run_b <= 1'b1;
      halt_b <= 1'b1;
      tick(6);
   endtask
   task automatic halt;
      halt_b <= 1'b0;
      tick(6);
      halt_b <= 1'b1;
      tick(4);
   endtask
   task automatic strobe(input logic [7:0] b);
      data_in <= b;
      tick(1);
      tx_holding_strobe_b <= 1'b0;
      tick(13);
      chk(tx_holding_vacant_b, 1);
      tx_holding_strobe_b <= 1'b1;
      tick(2);
   endtask
   task automatic shift(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         rx_bit_valid <= 1'b1;
         rx_bit <= b[7-i];
         tick(1);
         rx_bit_valid <= 1'b0;
         tick(1);
      end
   endtask
   task automatic drive(input logic [7:0] b);
      rx_bus_drive_b <= 1'b0;
      tick(6);
      chk(data_out, b);
      chk(data_oe, 1);
      rx_bus_drive_b <= 1'b1;
      tick(6);
      chk({rx_byte_waiting_b, short_byte_error_b, data_oe}, 8'h06);
   endtask
   // ----
   // Test sequence
   // ----
   initial begin
      tick(5);
      rst_b <= 1'b1;
      tick(2);
      chk({ready_b, tx_holding_vacant_b}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         unit_pick_lo <= ~i[0];
         unit_pick_hi <= ~i[1];
         tick(2);
         chk({4'h0, unit_select}, 8'h01 << i);
      end
      at_start <= 1'b1;
      run(1'b0, 1'b0);
      chk({tape_start_mark_b, motor_rev}, 8'h00);
      at_start <= 1'b0;
      past_load_mark <= 1'b1;
      run(1'b1, 1'b0);
      chk({motor_fwd, ready_b}, 8'h02);
      past_end_warning <= 1'b1;
      gap_seen <= 1'b1;
      tick(2);
      chk({ready_b, gap_detected_b}, 8'h02);
      past_end_warning <= 1'b0;
      gap_seen <= 1'b0;
      halt();
      chk(motor_fwd, 0);
      run(1'b1, 1'b1);
      chk(motor_fwd, 0);
      run(1'b0, 1'b0);
      chk(motor_rev, 1);
      halt();
      write_mode_level <= 1'b0;
      write_permit <= 1'b0;
      run(1'b1, 1'b0);
      chk({head_current, ready_b}, 8'h03);
      write_permit <= 1'b1;
      tick(2);
      chk(ready_b, 0);
      strobe(8'ha5);
      chk(tx_byte, 8'ha5);
      tick(2);
      chk(tx_byte_valid, 1);
      tick(18);
      chk(tx_holding_vacant_b, 0);
      strobe(8'h5a);
      chk(tx_byte, 8'h5a);
      chk(tx_holding_vacant_b, 1);
      tick(40);
      chk(tx_holding_vacant_b, 0);
      halt();
      write_mode_level <= 1'b1;
      run(1'b1, 1'b0);
      shift(8'hff, 8);
      tick(4);
      chk({rx_byte_waiting_b, short_byte_error_b}, 8'h03);
      shift(8'h3c, 8);
      tick(14);
      chk({rx_byte_waiting_b, short_byte_error_b}, 8'h01);
      drive(8'h3c);
      shift(8'h80, 3);
      rx_frame_end <= 1'b1;
      tick(1);
      rx_frame_end <= 1'b0;
      tick(4);
      chk({rx_byte_waiting_b, short_byte_error_b}, 8'h00);
      rx_bus_drive_b <= 1'b0;
      tick(6);
      rx_bus_drive_b <= 1'b1;
      tick(6);
      chk(short_byte_error_b, 1);
      host_reset_b <= 1'b0;
      tick(13);
      chk({motor_fwd, ready_b}, 8'h00);
      host_reset_b <= 1'b1;
      tick(4);
      results();
   end
endmodule
